// File: rtl/feq_pkg.sv
// Purpose: Shared constants for the channel-A equalizer coefficient block
// Assumes: Byte-addressed register port, 24-bit data, 12-bit samples
// Notes:   Coefficient offsets are byte addresses; registers may be 2 or 3 bytes

package feq_pkg;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 24;

  localparam logic [ADDR_W-1:0] ADDR_CFG        = 12'h410;
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 12'h411;
  localparam logic [ADDR_W-1:0] ADDR_TAP4       = 12'h41e;
  localparam logic [ADDR_W-1:0] ADDR_CENTER     = 12'h420;
  localparam logic [ADDR_W-1:0] ADDR_TAP6       = 12'h423;
  localparam logic [ADDR_W-1:0] ADDR_TAP7       = 12'h425;
  localparam logic [ADDR_W-1:0] ADDR_TAP8       = 12'h427;

  // ----------------------------------------------------------------
  // Coefficient layout
  // ----------------------------------------------------------------
  localparam int NUM_TAPS   = 9;
  localparam int CENTER_IDX = 4;
  localparam int SIDE_W     = 12;
  localparam int CENTER_W   = 18;
  localparam int FRAC_W     = 16;

  localparam logic [SIDE_W-1:0]   SIDE_RESET   = 12'h000;
  localparam logic [CENTER_W-1:0] CENTER_RESET = 18'h00000;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  localparam int MODE_LSB  = 0;
  localparam int MODE_W    = 2;
  localparam int SCW_LSB   = 2;
  localparam int SCW_W     = 3;
  localparam int MERGE_BIT = 5;

  localparam logic [MODE_W-1:0] MODE_BYPASS = 2'h0;
  localparam logic [MODE_W-1:0] MODE_ENABLE = 2'h2;
  localparam logic [SCW_W-1:0]  SCW_MAX     = 3'h6;
  localparam logic [SCW_W-1:0]  SCW_RESET   = 3'h0;

  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_RSVD_BIT   = 1;
  localparam int STAT_MERGE_BIT  = 2;
  localparam int STAT_LEVEL_LSB  = 3;

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  localparam int SAMPLE_W   = 12;
  localparam int ACC_W      = 36;
  localparam int FIFO_DEPTH = 4;
  localparam int LEVEL_W    = 3;

  typedef enum logic {
    PHASE_A,
    PHASE_B
  } feq_phase_type;

endpackage

// File: rtl/feq_fifo.sv
// Purpose: Small synchronous FIFO between the filter and the serial path
// Assumes: DEPTH is a power of two; one clock
// Notes:   Full and empty come from an occupancy count, not pointer guesses

`timescale 1ns/1ps

module feq_fifo #(
  parameter int WIDTH   = 12,
  parameter int DEPTH   = 4,
  parameter int LEVEL_W = 3
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_sync_n,
  input  wire logic               in_valid,
  output logic                    in_ready,
  input  wire logic [WIDTH-1:0]   in_data,
  output logic                    out_valid,
  input  wire logic               out_ready,
  output logic      [WIDTH-1:0]   out_data,
  output logic      [LEVEL_W-1:0] level
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (level != LEVEL_W'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + PTR_W'(1);
      end
      if (push && !pop) begin
        level <= level + LEVEL_W'(1);
      end else if (pop && !push) begin
        level <= level - LEVEL_W'(1);
      end
    end
  end

endmodule

// File: rtl/feq_equalizer.sv
// Purpose: Channel-A equalizer coefficients for taps four to eight and the
//          nine-tap filter datapath they steer
// Assumes: Taps one to three and nine arrive from the neighbouring block
// Notes:   Output goes through a four-word FIFO toward the serial path

`timescale 1ns/1ps

module feq_equalizer (
  input  wire logic                             clk_sys,
  input  wire logic                             rst_n,
  input  wire logic [feq_pkg::ADDR_W-1:0]       reg_addr,
  input  wire logic [feq_pkg::DATA_W-1:0]       reg_wdata,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  output logic      [feq_pkg::DATA_W-1:0]       reg_rdata,
  input  wire logic                             serial_link_enable,
  input  wire logic [feq_pkg::SIDE_W-1:0]       ext_tap1_coeff,
  input  wire logic [feq_pkg::SIDE_W-1:0]       ext_tap2_coeff,
  input  wire logic [feq_pkg::SIDE_W-1:0]       ext_tap3_coeff,
  input  wire logic [feq_pkg::SIDE_W-1:0]       ext_tap9_coeff,
  input  wire logic                             in_valid,
  output logic                                  in_ready,
  input  wire logic [feq_pkg::SAMPLE_W-1:0]     in_sample_a,
  input  wire logic [feq_pkg::SAMPLE_W-1:0]     in_sample_b,
  output logic                                  out_valid,
  input  wire logic                             out_ready,
  output logic      [feq_pkg::SAMPLE_W-1:0]     out_sample
);

  import feq_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------
  // Configuration and coefficient registers
  // ----------------------------------------------------------------
  logic        [MODE_W-1:0]   equalizer_mode_select;
  logic        [SCW_W-1:0]    side_coeff_weight;
  logic                       equalizer_merge_flag;
  logic signed [SIDE_W-1:0]   chan_a_tap4_coeff;
  logic signed [CENTER_W-1:0] chan_a_center_tap_coeff;
  logic signed [SIDE_W-1:0]   chan_a_tap6_coeff;
  logic signed [SIDE_W-1:0]   chan_a_tap7_coeff;
  logic signed [SIDE_W-1:0]   chan_a_tap8_coeff;

  // Link enable is not checked: software keeps writes to idle periods
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      equalizer_mode_select <= MODE_BYPASS;
      side_coeff_weight     <= SCW_RESET;
      equalizer_merge_flag  <= 1'b0;
    end else if (reg_wr && reg_addr == ADDR_CFG) begin
      equalizer_mode_select <= reg_wdata[MODE_LSB +: MODE_W];
      side_coeff_weight     <= reg_wdata[SCW_LSB +: SCW_W];
      equalizer_merge_flag  <= reg_wdata[MERGE_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      chan_a_tap4_coeff       <= SIDE_RESET;
      chan_a_center_tap_coeff <= CENTER_RESET;
      chan_a_tap6_coeff       <= SIDE_RESET;
      chan_a_tap7_coeff       <= SIDE_RESET;
      chan_a_tap8_coeff       <= SIDE_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_TAP4: begin
          chan_a_tap4_coeff <= reg_wdata[SIDE_W-1:0];
        end
        ADDR_CENTER: begin
          chan_a_center_tap_coeff <= reg_wdata[CENTER_W-1:0];
        end
        ADDR_TAP6: begin
          chan_a_tap6_coeff <= reg_wdata[SIDE_W-1:0];
        end
        ADDR_TAP7: begin
          chan_a_tap7_coeff <= reg_wdata[SIDE_W-1:0];
        end
        ADDR_TAP8: begin
          chan_a_tap8_coeff <= reg_wdata[SIDE_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Derived settings
  // ----------------------------------------------------------------
  logic             filter_on;
  logic             mode_reserved;
  logic [SCW_W-1:0] weight_used;

  assign filter_on     = (equalizer_mode_select == MODE_ENABLE);
  assign mode_reserved = !filter_on && (equalizer_mode_select != MODE_BYPASS);
  // Weights beyond the legal range saturate rather than overflow the sum
  assign weight_used   = (side_coeff_weight > SCW_MAX) ? SCW_MAX : side_coeff_weight;

  // ----------------------------------------------------------------
  // Register read-back
  // ----------------------------------------------------------------
  logic [LEVEL_W-1:0] fifo_level;
  logic [DATA_W-1:0]  next_rdata;

  always_comb begin
    next_rdata = '0;
    unique case (reg_addr)
      ADDR_CFG: begin
        next_rdata[MODE_LSB +: MODE_W] = equalizer_mode_select;
        next_rdata[SCW_LSB +: SCW_W]   = side_coeff_weight;
        next_rdata[MERGE_BIT]          = equalizer_merge_flag;
      end
      ADDR_STATUS: begin
        next_rdata[STAT_ACTIVE_BIT]              = filter_on;
        next_rdata[STAT_RSVD_BIT]                = mode_reserved;
        next_rdata[STAT_MERGE_BIT]               = equalizer_merge_flag;
        next_rdata[STAT_LEVEL_LSB +: LEVEL_W]    = fifo_level;
      end
      ADDR_TAP4: begin
        next_rdata[SIDE_W-1:0] = chan_a_tap4_coeff;
      end
      ADDR_CENTER: begin
        next_rdata[CENTER_W-1:0] = chan_a_center_tap_coeff;
      end
      ADDR_TAP6: begin
        next_rdata[SIDE_W-1:0] = chan_a_tap6_coeff;
      end
      ADDR_TAP7: begin
        next_rdata[SIDE_W-1:0] = chan_a_tap7_coeff;
      end
      ADDR_TAP8: begin
        next_rdata[SIDE_W-1:0] = chan_a_tap8_coeff;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // Data only valid the cycle after a read strobe; zero otherwise
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Tap coefficient assembly
  // ----------------------------------------------------------------
  logic signed [SIDE_W-1:0] side_coeff [NUM_TAPS];

  // Same tap mapping serves dual and merged modes
  always_comb begin
    side_coeff[0] = ext_tap1_coeff;
    side_coeff[1] = ext_tap2_coeff;
    side_coeff[2] = ext_tap3_coeff;
    side_coeff[3] = chan_a_tap4_coeff;
    side_coeff[4] = SIDE_RESET;
    side_coeff[5] = chan_a_tap6_coeff;
    side_coeff[6] = chan_a_tap7_coeff;
    side_coeff[7] = chan_a_tap8_coeff;
    side_coeff[8] = ext_tap9_coeff;
  end

  // ----------------------------------------------------------------
  // Input sequencing and delay line
  // ----------------------------------------------------------------
  feq_phase_type             phase;
  logic signed [SAMPLE_W-1:0] delay_line [NUM_TAPS];
  logic                      fifo_in_ready;
  logic                      res_valid;
  logic                      step;
  logic signed [SAMPLE_W-1:0] next_sample;

  // The pipeline advances only when the result slot is empty or can drain
  assign step = in_valid && (!res_valid || fifo_in_ready);

  // Merged mode takes A then B from one beat, so the beat is held one cycle
  assign in_ready = (!res_valid || fifo_in_ready)
                    && (!equalizer_merge_flag || phase == PHASE_B);

  assign next_sample = (equalizer_merge_flag && phase == PHASE_B)
                       ? in_sample_b : in_sample_a;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phase <= PHASE_A;
    end else if (!equalizer_merge_flag) begin
      phase <= PHASE_A;
    end else if (step) begin
      unique case (phase)
        PHASE_A: phase <= PHASE_B;
        PHASE_B: phase <= PHASE_A;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < NUM_TAPS; i++) begin
        delay_line[i] <= '0;
      end
    end else if (step) begin
      delay_line[0] <= next_sample;
      for (int i = 1; i < NUM_TAPS; i++) begin
        delay_line[i] <= delay_line[i-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Multiply-accumulate
  // ----------------------------------------------------------------
  logic signed [ACC_W-1:0]    acc;
  logic signed [ACC_W-1:0]    scaled;
  logic signed [SAMPLE_W-1:0] filtered;
  logic signed [SAMPLE_W-1:0] window [NUM_TAPS];

  // Window includes the sample being shifted in this cycle
  always_comb begin
    window[0] = next_sample;
    for (int i = 1; i < NUM_TAPS; i++) begin
      window[i] = delay_line[i-1];
    end
  end

  // Everything is summed in units of two to the minus sixteen
  always_comb begin
    acc = '0;
    for (int i = 0; i < NUM_TAPS; i++) begin
      if (i == CENTER_IDX) begin
        acc = acc + ACC_W'(window[i]) * ACC_W'(chan_a_center_tap_coeff);
      end else begin
        acc = acc + ((ACC_W'(window[i]) * ACC_W'(side_coeff[i])) <<< weight_used);
      end
    end
  end

  // Drop the fraction and saturate to the sample width
  localparam logic signed [ACC_W-1:0] SAT_MAX = ACC_W'((1 <<< (SAMPLE_W - 1)) - 1);
  localparam logic signed [ACC_W-1:0] SAT_MIN = -ACC_W'(1 <<< (SAMPLE_W - 1));

  always_comb begin
    scaled = acc >>> FRAC_W;
    if (scaled > SAT_MAX) begin
      filtered = SAMPLE_W'(SAT_MAX);
    end else if (scaled < SAT_MIN) begin
      filtered = SAMPLE_W'(SAT_MIN);
    end else begin
      filtered = scaled[SAMPLE_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Result register
  // ----------------------------------------------------------------
  logic [SAMPLE_W-1:0] result;

  // Bypass and reserved modes pass the raw sample
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      result    <= '0;
      res_valid <= 1'b0;
    end else if (step) begin
      result    <= filter_on ? filtered : next_sample;
      res_valid <= 1'b1;
    end else if (fifo_in_ready) begin
      res_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Output FIFO
  // ----------------------------------------------------------------
  feq_fifo #(
    .WIDTH   (SAMPLE_W),
    .DEPTH   (FIFO_DEPTH),
    .LEVEL_W (LEVEL_W)
  ) u_fifo (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .in_valid   (res_valid),
    .in_ready   (fifo_in_ready),
    .in_data    (result),
    .out_valid  (out_valid),
    .out_ready  (out_ready),
    .out_data   (out_sample),
    .level      (fifo_level)
  );

endmodule

// File: test/feq_sink_model.sv
// Purpose: Serial output path stand-in that drains the equalizer FIFO
// Assumes: One clock; hold forces a full stall
// Notes:   Random stalls keep the FIFO under backpressure

`timescale 1ns/1ps

module feq_sink_model (
  input  wire logic clk_sys,
  input  wire logic hold,
  output logic      out_ready
);
  initial out_ready = 1'b0;

  // Stalls one cycle in four, so back-to-back pops and waits both occur
  always @(posedge clk_sys) out_ready <= !hold && ($urandom % 4 != 0);
endmodule

// File: test/feq_equalizer_checker.sv
// Purpose: Port-level assertions for the channel-A equalizer
// Assumes: Config writes happen while the stream is idle
// Notes:   Mode and merge are shadowed from register writes

`timescale 1ns/1ps

module feq_equalizer_checker
  import feq_pkg::*;
(
  input wire logic                         clk_sys,
  input wire logic                         rst_n,
  input wire logic [feq_pkg::ADDR_W-1:0]   reg_addr,
  input wire logic [feq_pkg::DATA_W-1:0]   reg_wdata,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [feq_pkg::DATA_W-1:0]   reg_rdata,
  input wire logic                         in_valid,
  input wire logic                         in_ready,
  input wire logic                         out_valid,
  input wire logic                         out_ready,
  input wire logic [feq_pkg::SAMPLE_W-1:0] out_sample
);
  logic [MODE_W-1:0] sh_mode;
  logic              sh_merge;
  logic              side_rd;
  logic              map_rd;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sh_mode  <= MODE_BYPASS;
      sh_merge <= 1'b0;
    end else if (reg_wr && reg_addr == ADDR_CFG) begin
      sh_mode  <= reg_wdata[MODE_LSB +: MODE_W];
      sh_merge <= reg_wdata[MERGE_BIT];
    end
  end

  assign side_rd = reg_rd && (reg_addr inside {ADDR_TAP4, ADDR_TAP6, ADDR_TAP7, ADDR_TAP8});
  assign map_rd  = side_rd || (reg_rd && (reg_addr inside {ADDR_CFG, ADDR_STATUS, ADDR_CENTER}));

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_take;
    in_valid && in_ready;
  endsequence

  chk_rdata_zero: assert property (!map_rd |=> reg_rdata == '0)
    else $error("read data not zero");
  chk_center_rsvd: assert property (s_rd(ADDR_CENTER) |=> reg_rdata[23:18] == '0)
    else $error("center reserved bits set");
  chk_side_rsvd: assert property (side_rd |=> reg_rdata[23:12] == '0)
    else $error("side reserved bits set");
  chk_status_bits: assert property (s_rd(ADDR_STATUS) |=> reg_rdata[2:0] ==
      {sh_merge, sh_mode[0], sh_mode == MODE_ENABLE} && reg_rdata[23:6] == '0)
    else $error("status bits wrong");
  chk_cfg_back: assert property (s_rd(ADDR_CFG) |=> reg_rdata[1:0] == sh_mode
      && reg_rdata[5] == sh_merge && reg_rdata[23:6] == '0)
    else $error("config readback wrong");
  chk_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_sample))
    else $error("output dropped while stalled");
  chk_out_latency: assert property (s_take |-> ##[1:2] out_valid)
    else $error("result late");
  chk_merge_pair: assert property ((sh_merge and s_take) |-> $past(in_valid) && !$past(in_ready))
    else $error("merged beat not two cycles");
  chk_dual_stall: assert property (!sh_merge && in_valid && !in_ready |-> out_valid)
    else $error("stall with empty FIFO");
endmodule

bind feq_equalizer feq_equalizer_checker u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
  .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready), .out_sample(out_sample)
);

// File: test/tb_feq_equalizer.sv
// Purpose: Self-checking bench for the channel-A equalizer
// Assumes: Registers change only with the link off and the stream idle
// Notes:   Filter history is unknown after a mode change; first 8 filtered results skip

`timescale 1ns/1ps

module tb_feq_equalizer;
  import feq_pkg::*;
  logic                clk_sys, rst_n, reg_wr, reg_rd, rd_d, link_en, in_valid, in_ready;
  logic                out_valid, out_ready, hold, merge;
  logic [ADDR_W-1:0]   reg_addr;
  logic [DATA_W-1:0]   reg_wdata, reg_rdata, v;
  logic [SIDE_W-1:0]   ext_c [4];
  logic [SAMPLE_W-1:0] in_sample_a, in_sample_b, out_sample;
  logic [SAMPLE_W:0]   e;
  logic [MODE_W-1:0]   mode;
  logic [DATA_W-1:0]   rq [$];
  logic [SAMPLE_W:0]   sq [$];
  longint              coef [9];
  longint              hist [9];
  int                  scw, warm, n_fail, comparisons;
  logic [ADDR_W-1:0]   ta [5] = '{ADDR_TAP4, ADDR_CENTER, ADDR_TAP6, ADDR_TAP7, ADDR_TAP8};
  int                  ti [5] = '{3, 4, 5, 6, 7};
  int                  ei [4] = '{0, 1, 2, 8};

  feq_equalizer u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_link_enable(link_en),
    .ext_tap1_coeff(ext_c[0]), .ext_tap2_coeff(ext_c[1]), .ext_tap3_coeff(ext_c[2]),
    .ext_tap9_coeff(ext_c[3]), .in_valid(in_valid), .in_ready(in_ready),
    .in_sample_a(in_sample_a), .in_sample_b(in_sample_b), .out_valid(out_valid),
    .out_ready(out_ready), .out_sample(out_sample)
  );
  feq_sink_model u_sink (.clk_sys(clk_sys), .hold(hold), .out_ready(out_ready));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic bad(input string m);
    n_fail++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic chk_reg(input logic [DATA_W-1:0] g, x);
    comparisons++;
    if (g !== x) bad($sformatf("reg %h exp %h", g, x));
  endtask
  task automatic chk_smp(input logic [SAMPLE_W-1:0] g, x);
    comparisons++;
    if (g !== x) bad($sformatf("sample %h exp %h", g, x));
  endtask
  task automatic chk_bit(input logic g, x);
    comparisons++;
    if (g !== x) bad("flag wrong");
  endtask

  // Bus strobes are set once per cycle, so calls may follow with no gap
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
    reg_addr <= a; reg_rd <= 1'b1; reg_wr <= 1'b0; rq.push_back(x);
    @(posedge clk_sys);
  endtask
  task automatic idle();
    reg_wr <= 1'b0; reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask
  function automatic logic [DATA_W-1:0] st(input logic [1:0] m, input logic g, input int l);
    st = {18'h0, 3'(l), g, m[0], m == MODE_ENABLE};
  endfunction

  function automatic logic [SAMPLE_W:0] model(input logic [SAMPLE_W-1:0] s);
    longint acc;
    for (int k = 8; k > 0; k--) hist[k] = hist[k-1];
    hist[0] = longint'(signed'(s));
    acc = 0;
    for (int k = 0; k < 9; k++) if (k != CENTER_IDX) acc += coef[k] * hist[k];
    acc = ((acc <<< scw) + coef[CENTER_IDX] * hist[CENTER_IDX]) >>> FRAC_W;
    if (acc > 2047) acc = 2047;
    if (acc < -2048) acc = -2048;
    if (mode != MODE_ENABLE) acc = hist[0];
    model = {warm > 0, acc[SAMPLE_W-1:0]};
    if (warm > 0) warm--;
  endfunction

  task automatic cfg(input logic [1:0] m, input int w, input logic g);
    wr(ADDR_CFG, {18'h0, g, 3'(w), m});
    rd(ADDR_CFG, {18'h0, g, 3'(w), m});
    idle();
    mode = m; merge = g; warm = (m == MODE_ENABLE) ? 8 : 0;
    scw = (w > int'(SCW_MAX)) ? int'(SCW_MAX) : w;
  endtask

  task automatic send(input logic [SAMPLE_W-1:0] a, b);
    int n;
    in_sample_a <= a; in_sample_b <= b; in_valid <= 1'b1;
    for (n = 0; n < 300; n++) begin
      @(negedge clk_sys);
      if (in_ready === 1'b1) break;
      @(posedge clk_sys);
    end
    if (n == 300) begin bad("input stuck"); results(); end
    sq.push_back(model(a));
    if (merge) sq.push_back(model(b));
    @(posedge clk_sys);
  endtask

  task automatic stream(input int n, input string name);
    int k;
    link_en <= 1'b1;
    repeat (n) send(12'($urandom), 12'($urandom));
    in_valid <= 1'b0;
    for (k = 0; k < 500 && sq.size() > 0; k++) @(posedge clk_sys);
    if (k == 500) begin bad("drain stuck"); results(); end
    link_en <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rd(ADDR_STATUS, st(mode, merge, 0));
    idle();
    $display("test %s done", name);
  endtask

  task automatic results();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    if (rd_d) chk_reg(reg_rdata, rq.pop_front());
    rd_d <= reg_rd;
    if (rst_n && out_valid === 1'b1 && out_ready) begin
      if (sq.size() == 0) bad("unexpected output");
      else begin
        e = sq.pop_front();
        if (!e[SAMPLE_W]) chk_smp(out_sample, e[SAMPLE_W-1:0]);
      end
    end
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    bad("run timeout");
    results();
  end

  initial begin
    void'($urandom(70));
    {rst_n, reg_wr, reg_rd, rd_d, link_en, in_valid, hold, merge} = '0;
    reg_addr = '0; reg_wdata = '0; in_sample_a = '0; in_sample_b = '0;
    foreach (ext_c[j]) ext_c[j] = '0;
    coef = '{default: 0}; hist = '{default: 0};
    {scw, warm, n_fail, comparisons} = '0;
    mode = MODE_BYPASS;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // ------------------------------------------------------------
    // Registers: reset, reserved bits, unmapped places
    // ------------------------------------------------------------
    foreach (ta[i]) rd(ta[i], '0);
    rd(ADDR_CFG, '0);
    wr(12'h421, 24'hffffff);
    rd(12'h421, '0);
    for (int p = 0; p < 2; p++) begin
      foreach (ta[i]) begin
        v = p ? 24'($urandom) : 24'hffffff;
        wr(ta[i], v);
        rd(ta[i], v & ((i == 1) ? 24'h03ffff : 24'h000fff));
        coef[ti[i]] = (i == 1) ? longint'(signed'(v[17:0])) : longint'(signed'(v[11:0]));
      end
    end
    idle();
    $display("test registers done");
    foreach (ei[j]) begin
      v = 24'($urandom);
      ext_c[j] <= v[11:0];
      coef[ei[j]] = longint'(signed'(v[11:0]));
    end
    for (int m = 0; m < 4; m++) begin
      cfg(2'(m), 0, 1'b0);
      stream(4, "mode");
    end
    // Full FIFO plus result slot refuses the sixth beat
    cfg(MODE_BYPASS, 0, 1'b0);
    hold <= 1'b1;
    repeat (5) send(12'($urandom), 12'h000);
    fork
      send(12'h7ff, 12'h000);
      begin
        repeat (3) begin
          @(negedge clk_sys);
          chk_bit(in_ready, 1'b0);
        end
        @(posedge clk_sys);
        hold <= 1'b0;
      end
    join
    stream(0, "fill");
    // Weight 7 is out of range and must act as 6
    for (int p = 0; p < 4; p++) begin
      cfg(MODE_ENABLE, (p < 3) ? p * 3 : 7, 1'b0);
      stream(20, "dual");
    end
    cfg(MODE_ENABLE, 2, 1'b1);
    stream(12, "merged");
    results();
  end
endmodule
